// ---- rtl/padi_pkg.sv ----
// Overview of operation
// - each clock edge captures a sample; its word appears after the fifth following edge
// - mode pins high,low: 00 power down, 01 mode 1, 10 mode 2, 11 mode 3
// - mode 1 gain one, mode 2 gain half, mode 3 gain one with minus 1 V offset
// - strap low selects internal reference, strap high selects external reference
// - result drives twelve data lines, bit 0 least significant, bit 11 most
// - enable pin switches data drivers off; when on they drive the current result
// - sample outside the span raises over-range flag together with its result
// - result is unsigned binary, lowest input all zeros, highest all ones
// - enable pin acts without waiting for any clock edge
package padi_pkg;

  // ---------------------------------------------------------------
  // conversion
  // ---------------------------------------------------------------
  localparam int CODE_W       = 12;
  localparam int SAMPLE_W     = 16;
  localparam int VP_W         = 18;
  localparam int PIPE_LATENCY = 5;
  // front-end voltages in steps of 1/4096 V, so one volt is 4096 steps
  localparam logic signed [VP_W-1:0] FS_POS      = 18'h0_0FFF;
  localparam logic signed [VP_W-1:0] FS_NEG      = -18'sh1_000;
  localparam logic signed [VP_W-1:0] OFFSET_M3   = 18'h0_1000;
  localparam int                     CODE_SHIFT  = 1;
  localparam logic [CODE_W-1:0]      CODE_MIN    = 12'h000;
  localparam logic [CODE_W-1:0]      CODE_MAX    = 12'hFFF;

  typedef enum logic [1:0] {
    MODE_POWER_DOWN = 2'b00,
    MODE_GAIN_ONE   = 2'b01,
    MODE_GAIN_HALF  = 2'b10,
    MODE_OFFSET     = 2'b11
  } padi_mode_t;

  typedef struct packed {
    logic              valid;
    logic              over;
    logic [CODE_W-1:0] code;
  } padi_word_t;

  localparam int WORD_W = $bits(padi_word_t);

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 8;
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_RESULT   = 8'h08;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h0C;
  localparam logic [7:0]  ADDR_INT_MASK = 8'h10;

  localparam int CTRL_FORCE_PD   = 0;
  localparam int ST_MODE_LSB     = 0;
  localparam int ST_POWER_DOWN   = 2;
  localparam int ST_REF_EXTERNAL = 3;
  localparam int ST_VALID        = 4;
  localparam int RES_OVER        = 12;
  localparam int RES_VALID       = 13;
  localparam int INT_OVER        = 0;
  localparam int INT_MODE        = 1;
  localparam int INT_W           = 2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

endpackage : padi_pkg

// ---- rtl/padi_pipe.sv ----
`timescale 1ns/100ps
module padi_pipe #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 5
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] in_word,
  output logic      [WIDTH-1:0] out_word
);

  logic [WIDTH-1:0] stage [DEPTH];

  // ---------------------------------------------------------------
  // shift chain; the last stage is the output register
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_stage
      always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
          stage[i] <= '0;
        end else if (i == 0) begin
          stage[i] <= in_word;
        end else begin
          stage[i] <= stage[(i == 0) ? 0 : i-1];
        end
      end
    end
  endgenerate

  assign out_word = stage[DEPTH-1];

endmodule : padi_pipe

// ---- rtl/padi_top.sv ----
`timescale 1ns/100ps
module padi_top #(
  parameter int LATENCY = padi_pkg::PIPE_LATENCY
) (
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset,
  input  wire logic signed [padi_pkg::SAMPLE_W-1:0]  analog_input_pos,
  input  wire logic signed [padi_pkg::SAMPLE_W-1:0]  analog_input_neg,
  input  wire logic                                  mode_select_high,
  input  wire logic                                  mode_select_low,
  input  wire logic                                  reference_source_strap,
  input  wire logic                                  output_enable_n,
  output logic             [padi_pkg::CODE_W-1:0]    result_data,
  output logic             [padi_pkg::CODE_W-1:0]    result_data_oe_n,
  output logic                                       over_range_pin,
  output logic                                       result_valid,
  output logic                                       ref_internal_en,
  output logic                                       power_down,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic        [padi_pkg::ADDR_W-1:0]    paddr,
  input  wire logic        [31:0]                    pwdata,
  output logic             [31:0]                    prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  output logic                                       irq
);
  import padi_pkg::*;

  // ---------------------------------------------------------------
  // configuration pins
  // ---------------------------------------------------------------
  padi_mode_t        mode;
  padi_mode_t        mode_prev;
  logic              strap_taken;
  logic              force_pd;
  logic              mode_changed;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode      <= MODE_POWER_DOWN;
      mode_prev <= MODE_POWER_DOWN;
    end else begin
      mode      <= padi_mode_t'({mode_select_high, mode_select_low});
      mode_prev <= mode;
    end
  end

  assign mode_changed = (mode != mode_prev);

  // strap is caught once after reset release, never under the reset itself
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      strap_taken     <= 1'b0;
      ref_internal_en <= 1'b1;
    end else if (!strap_taken) begin
      strap_taken     <= 1'b1;
      ref_internal_en <= ~reference_source_strap;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      power_down <= 1'b1;
    end else begin
      power_down <= (mode == MODE_POWER_DOWN) || force_pd;
    end
  end

  // ---------------------------------------------------------------
  // sample and hold scaling and quantiser
  // ---------------------------------------------------------------
  logic signed [VP_W-1:0] diff;
  logic signed [VP_W-1:0] vp;
  logic signed [VP_W-1:0] shifted;
  padi_word_t             next_word;

  always_comb begin
    diff = VP_W'(analog_input_pos) - VP_W'(analog_input_neg);
    unique case (mode)
      MODE_GAIN_HALF: vp = diff >>> 1;
      MODE_OFFSET:    vp = diff - OFFSET_M3;
      default:        vp = diff;
    endcase
    shifted = (vp - FS_NEG) >>> CODE_SHIFT;
    next_word.valid = !power_down && !mode_changed;
    next_word.over  = (vp > FS_POS) || (vp < FS_NEG);
    // unsigned offset binary, clamped at both ends of the span
    if (vp > FS_POS) begin
      next_word.code = CODE_MAX;
    end else if (vp < FS_NEG) begin
      next_word.code = CODE_MIN;
    end else begin
      next_word.code = shifted[CODE_W-1:0];
    end
    // power down freezes the chain input at zero so the converter idles
    if (power_down) begin
      next_word = '0;
    end
  end

  // ---------------------------------------------------------------
  // pipeline: capture at edge k, word out after edge k+LATENCY
  // ---------------------------------------------------------------
  padi_word_t out_word;

  // stage zero is the sampling flop, so LATENCY more stages follow it
  padi_pipe #(
    .WIDTH (WORD_W),
    .DEPTH (LATENCY + 1)
  ) u_pipe (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .in_word  (next_word),
    .out_word (out_word)
  );

  // the pipe's last stage is a flop, so these follow it directly
  assign result_data    = out_word.code;
  assign over_range_pin = out_word.over;
  assign result_valid   = out_word.valid;

  // enable is combinational on purpose: drivers must react without a clock
  assign result_data_oe_n = {CODE_W{output_enable_n}};

  // ---------------------------------------------------------------
  // interrupt sources
  // ---------------------------------------------------------------
  logic [INT_W-1:0] int_stat;
  logic [INT_W-1:0] int_mask;
  logic [INT_W-1:0] int_event;
  logic [INT_W-1:0] int_clear;

  always_comb begin
    int_event           = '0;
    int_event[INT_OVER] = out_word.valid && out_word.over;
    int_event[INT_MODE] = mode_changed;
  end

  // ---------------------------------------------------------------
  // APB slave, one wait state so read data come from a flop
  // ---------------------------------------------------------------
  logic access;
  logic wr_done;
  logic mapped;

  assign access  = psel && penable && !pready;
  assign wr_done = psel && penable && pready && pwrite;

  always_comb begin
    unique case (paddr)
      ADDR_CTRL, ADDR_STATUS, ADDR_RESULT, ADDR_INT_STAT, ADDR_INT_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access && !mapped;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata <= RESET_WORD;
    end else if (access && !pwrite) begin
      prdata <= RESET_WORD;
      unique case (paddr)
        ADDR_CTRL: begin
          prdata[CTRL_FORCE_PD] <= force_pd;
        end
        ADDR_STATUS: begin
          prdata[ST_MODE_LSB +: 2] <= mode;
          prdata[ST_POWER_DOWN]    <= power_down;
          prdata[ST_REF_EXTERNAL]  <= ~ref_internal_en;
          prdata[ST_VALID]         <= out_word.valid;
        end
        ADDR_RESULT: begin
          prdata[CODE_W-1:0] <= out_word.code;
          prdata[RES_OVER]   <= out_word.over;
          prdata[RES_VALID]  <= out_word.valid;
        end
        ADDR_INT_STAT: begin
          prdata[INT_W-1:0] <= int_stat;
        end
        ADDR_INT_MASK: begin
          prdata[INT_W-1:0] <= int_mask;
        end
        default: begin
          prdata <= RESET_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      force_pd <= 1'b0;
    end else if (wr_done && paddr == ADDR_CTRL) begin
      force_pd <= pwdata[CTRL_FORCE_PD];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      int_mask <= '0;
    end else if (wr_done && paddr == ADDR_INT_MASK) begin
      int_mask <= pwdata[INT_W-1:0];
    end
  end

  assign int_clear = (wr_done && paddr == ADDR_INT_STAT) ? pwdata[INT_W-1:0] : '0;

  // a new event in the clearing cycle wins over the write-one-to-clear
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      int_stat <= '0;
    end else begin
      int_stat <= (int_stat & ~int_clear) | int_event;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_stat & ~int_clear) | int_event) & int_mask);
    end
  end

endmodule : padi_top

// ---- sim/padi_properties.sv ----
`timescale 1ns/100ps
module padi_properties
  import padi_pkg::*;
#(
  parameter int LATENCY = padi_pkg::PIPE_LATENCY
) (
  input wire logic                                 ref_clk,
  input wire logic                                 reset,
  input wire logic signed [padi_pkg::SAMPLE_W-1:0] analog_input_pos,
  input wire logic signed [padi_pkg::SAMPLE_W-1:0] analog_input_neg,
  input wire logic                                 mode_select_high,
  input wire logic                                 mode_select_low,
  input wire logic                                 reference_source_strap,
  input wire logic                                 output_enable_n,
  input wire logic        [padi_pkg::CODE_W-1:0]   result_data,
  input wire logic        [padi_pkg::CODE_W-1:0]   result_data_oe_n,
  input wire logic                                 over_range_pin,
  input wire logic                                 result_valid,
  input wire logic                                 ref_internal_en,
  input wire logic                                 power_down
);
  logic signed [VP_W-1:0]   d_q [LATENCY+1];
  logic        [1:0]        m_q [LATENCY+3];
  logic signed [VP_W-1:0]   vp;
  logic                     exp_over;
  logic        [CODE_W-1:0] exp_code;

  // input difference and pin mode delayed to line up with each result
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      d_q <= '{default: '0};
      m_q <= '{default: '0};
    end else begin
      d_q[0] <= VP_W'(analog_input_pos) - VP_W'(analog_input_neg);
      m_q[0] <= {mode_select_high, mode_select_low};
      for (int i = 1; i <= LATENCY; i++) d_q[i] <= d_q[i-1];
      for (int i = 1; i <= LATENCY+2; i++) m_q[i] <= m_q[i-1];
    end
  end

  always_comb begin
    case (m_q[LATENCY+1])
      2'b10:   vp = d_q[LATENCY] >>> 1;
      2'b11:   vp = d_q[LATENCY] - OFFSET_M3;
      default: vp = d_q[LATENCY];
    endcase
    exp_over = (vp > FS_POS) || (vp < FS_NEG);
    exp_code = exp_over ? {CODE_W{!vp[VP_W-1]}} : CODE_W'((vp - FS_NEG) >>> CODE_SHIFT);
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_code_value: assert property (result_valid |-> result_data == exp_code)
    else $error("result code differs from model");
  a_over_flag: assert property (result_valid |-> over_range_pin == exp_over)
    else $error("over-range flag differs from model");
  a_valid_gate: assert property (result_valid |-> m_q[LATENCY+1] != 2'b00 && m_q[LATENCY+1] == m_q[LATENCY+2])
    else $error("valid word from power down or mode change");
  a_pd_decode: assert property (({mode_select_high, mode_select_low} == 2'b00) [*3] |-> power_down)
    else $error("mode pins low but not powered down");
  a_oe_follow: assert property (result_data_oe_n == {CODE_W{output_enable_n}})
    else $error("data enables do not follow enable pin");
  a_over_clamp: assert property (over_range_pin |-> result_data == '0 || result_data == '1)
    else $error("over-range word not clamped");
  a_ref_strap: assert property ($past(reset) && !reset |=> ref_internal_en == !$past(reference_source_strap))
    else $error("reference select differs from strap");
  a_strap_once: assert property (!$past(reset) && !$past(reset, 2) |-> $stable(ref_internal_en))
    else $error("reference select moved after start");

  cover property (result_valid && over_range_pin);
  cover property (power_down && !result_valid);
  cover property (output_enable_n);
endmodule : padi_properties

// ---- sim/padi_capture.sv ----
`timescale 1ns/100ps
module padi_capture (
  input  wire logic                         ref_clk,
  input  wire logic                         reset,
  input  wire logic [padi_pkg::CODE_W-1:0]  data_bus,
  input  wire logic                         over_in,
  input  wire logic                         valid_in,
  input  wire logic [1:0]                   mode_pins,
  output padi_pkg::padi_word_t              held
);
  import padi_pkg::*;
  // refill words, plus the pin register and the word flagged as a mode change
  localparam logic [2:0] SKIP_WORDS = 3'(PIPE_LATENCY + 2);
  logic [1:0] last_mode;
  logic [2:0] skip_cnt;

  // data taken an edge after it launches, so the output delay is covered
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      last_mode <= 2'b00;
      skip_cnt  <= SKIP_WORDS;
      held      <= '0;
    end else begin
      last_mode <= mode_pins;
      if (mode_pins != last_mode) skip_cnt <= SKIP_WORDS;
      else if (skip_cnt != 3'h0) skip_cnt <= skip_cnt - 3'h1;
      if (skip_cnt == 3'h0 && valid_in) held <= '{1'b1, over_in, data_bus};
    end
  end
endmodule : padi_capture

// ---- sim/test_pipelined_adc_digital_interface.sv ----
`timescale 1ns/100ps
module test_pipelined_adc_digital_interface;
  import padi_pkg::*;
  typedef struct {
    logic [1:0]         mode;
    logic signed [15:0] pos;
    logic signed [15:0] neg;
    logic [11:0]        code;
    logic               over;
  } padi_row_t;
  padi_row_t rows [10] = '{
    '{2'b01, 16'sh0000, 16'sh0000, 12'h800, 1'b0},
    '{2'b01, 16'sh0FFF, 16'sh0000, 12'hFFF, 1'b0},
    '{2'b01, 16'sh1000, 16'sh0000, 12'hFFF, 1'b1},
    '{2'b01, 16'shEFFF, 16'sh0000, 12'h000, 1'b1},
    '{2'b01, 16'sh0064, 16'shFF9C, 12'h864, 1'b0},
    '{2'b10, 16'sh1FFF, 16'sh0000, 12'hFFF, 1'b0},
    '{2'b10, 16'sh2000, 16'sh0000, 12'hFFF, 1'b1},
    '{2'b11, 16'sh1000, 16'sh0000, 12'h800, 1'b0},
    '{2'b11, 16'sh1FFF, 16'sh0000, 12'hFFF, 1'b0},
    '{2'b11, 16'shFFFF, 16'sh0000, 12'h000, 1'b1}};
  logic ref_clk = 1'b0, reset = 1'b1, mode_select_high = 1'b0, mode_select_low = 1'b1;
  logic reference_source_strap = 1'b0, output_enable_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic signed [SAMPLE_W-1:0] analog_input_pos = '0, analog_input_neg = '0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, prdata, rd;
  logic [CODE_W-1:0] result_data, result_data_oe_n, data_bus;
  logic over_range_pin, result_valid, ref_internal_en, power_down, pready, pslverr, irq, err;
  padi_word_t held;
  int n_fail = 0, check_count = 0;

  always #10 ref_clk = ~ref_clk;
  // a released line shows the inverse of the current result bit
  assign data_bus = result_data ^ result_data_oe_n;

  padi_top #(.LATENCY(PIPE_LATENCY)) dut_u (.ref_clk, .reset, .analog_input_pos,
    .analog_input_neg, .mode_select_high, .mode_select_low, .reference_source_strap,
    .output_enable_n, .result_data, .result_data_oe_n, .over_range_pin, .result_valid,
    .ref_internal_en, .power_down, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .irq);
  padi_capture cap_u (.ref_clk, .reset, .data_bus, .over_in(over_range_pin),
    .valid_in(result_valid), .mode_pins({mode_select_high, mode_select_low}), .held);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // values stand until the rising edge at which pready is seen high
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  initial begin
    #200_000;
    n_fail++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk(32'(ref_internal_en), 32'h0000_0001);
    foreach (rows[i]) begin
      @(posedge ref_clk);
      {mode_select_high, mode_select_low} <= rows[i].mode;
      analog_input_pos <= rows[i].pos;
      analog_input_neg <= rows[i].neg;
      repeat (10) @(posedge ref_clk);
      #1 chk(32'(held), 32'({1'b1, rows[i].over, rows[i].code}));
    end
    $display("test table done");
    @(posedge ref_clk);
    {mode_select_high, mode_select_low} <= 2'b01;
    analog_input_pos <= '0;
    repeat (10) @(posedge ref_clk);
    analog_input_pos <= 16'sh0FFF;
    repeat (5) @(posedge ref_clk);
    #1 chk(32'(result_data), 32'h0000_0800);
    @(posedge ref_clk);
    #1 chk(32'(result_data), 32'h0000_0FFF);
    @(posedge ref_clk);
    output_enable_n <= 1'b1;
    #1 chk(32'(result_data_oe_n), 32'h0000_0FFF);
    @(posedge ref_clk);
    output_enable_n <= 1'b0;
    #1 chk(32'(result_data_oe_n), 32'h0000_0000);
    $display("test latency and enable done");
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, ADDR_INT_MASK, 32'h0000_0003);
    repeat (2) @(posedge ref_clk);
    #1 chk(32'(irq), 32'h0000_0001);
    apb(1'b0, ADDR_INT_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, ADDR_INT_STAT, 32'h0000_0003);
    apb(1'b0, ADDR_INT_STAT, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    repeat (8) @(posedge ref_clk);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0005);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    $display("test registers done");
    {mode_select_high, mode_select_low} <= 2'b00;
    repeat (10) @(posedge ref_clk);
    #1 chk(32'({power_down, result_valid}), 32'h0000_0002);
    @(posedge ref_clk);
    reference_source_strap <= 1'b1;
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 chk(32'(ref_internal_en), 32'h0000_0000);
    $display("test power down and strap done");
    print_verdict();
  end
endmodule : test_pipelined_adc_digital_interface

bind padi_top padi_properties #(.LATENCY(LATENCY)) chk_u (.ref_clk, .reset, .analog_input_pos,
  .analog_input_neg, .mode_select_high, .mode_select_low, .reference_source_strap,
  .output_enable_n, .result_data, .result_data_oe_n, .over_range_pin, .result_valid,
  .ref_internal_en, .power_down);
